// File: srsl_top.sv
// Purpose: Status reporting and service request logic
// Assumes: Commands arrive as single-cycle strobes from the parser
// Notes:   Read answers appear one cycle after the command
`timescale 1ns/1ps
module srsl_top
  import srsl_pkg::*;
(
  input  wire logic                            sys_clk,
  input  wire logic                            nrst,
  input  wire logic                            cmd_valid,
  input  wire srsl_cmd_t                       cmd,
  output logic                                 rd_valid,
  output logic [REG_W-1:0]                     rd_data,
  input  wire logic [FILT_SETS-1:0][REG_W-1:0] cond_in,
  input  wire logic [REG_W-1:0]                std_event_in,
  input  wire logic                            err_push,
  input  wire logic [EQ_W-1:0]                 err_code,
  output logic                                 err_ready,
  input  wire logic                            oq_push,
  input  wire logic [OQ_W-1:0]                 oq_data,
  output logic                                 oq_ready,
  input  wire logic                            talk_pop,
  output logic                                 talk_valid,
  output logic [OQ_W-1:0]                      talk_data,
  output logic [7:0]                           status_byte,
  output logic                                 master_summary,
  output logic                                 srq
);
  // ************************************************************
  // Command decode
  // ************************************************************
  logic cmd_go;
  logic is_std;
  logic cls;
  logic preset;
  logic spoll;

  assign cmd_go = cmd_valid && (cmd.op != OP_NOP);
  assign is_std = (cmd.sel == SET_STD);
  assign cls    = cmd_valid && (cmd.op == OP_CLS);
  assign preset = cmd_valid && (cmd.op == OP_PRESET);
  assign spoll  = cmd_valid && (cmd.op == OP_SPOLL);

  // ************************************************************
  // Register sets
  // ************************************************************
  logic [FILT_SETS-1:0][REG_W-1:0] cond_eff;
  logic [FILT_SETS-1:0][REG_W-1:0] rise_q;
  logic [FILT_SETS-1:0][REG_W-1:0] fall_q;
  logic [FILT_SETS-1:0][REG_W-1:0] evt_q;
  logic [FILT_SETS-1:0][REG_W-1:0] en_q;
  logic [FILT_SETS-1:0]            sum;
  logic [REG_W-1:0]                std_evt;
  logic [REG_W-1:0]                std_en;
  logic                            std_event_summary_bit;

  // Trigger, arm and sequence summaries feed operation condition bits
  always_comb begin
    cond_eff                          = cond_in;
    cond_eff[SET_OPER][OPER_TRIG_BIT] = cond_in[SET_OPER][OPER_TRIG_BIT] | sum[SET_TRIG];
    cond_eff[SET_OPER][OPER_ARM_BIT]  = cond_in[SET_OPER][OPER_ARM_BIT] | sum[SET_ARM];
    cond_eff[SET_OPER][OPER_SEQ_BIT]  = cond_in[SET_OPER][OPER_SEQ_BIT] | sum[SET_SEQ];
  end

  for (genvar i = 0; i < FILT_SETS; i++) begin : g_set
    logic hit;
    assign hit = cmd_valid && !is_std && (cmd.sel == srsl_set_t'(i));
    srsl_status_set #(
      .HAS_FILTER  (1'b1),
      .PRESET_ONES (i >= int'(SET_TRIG))
    ) u_set (
      .sys_clk        (sys_clk),
      .nrst           (nrst),
      .cond           (cond_eff[i]),
      .direct         (ZERO16),
      .wdata          (cmd.data),
      .rise_we        (hit && (cmd.op == OP_WR_RISE)),
      .fall_we        (hit && (cmd.op == OP_WR_FALL)),
      .en_we          (hit && (cmd.op == OP_WR_EN)),
      .rd_clear       (hit && (cmd.op == OP_RD_EVENT)),
      .cls            (cls),
      .preset         (preset),
      .rising_filter  (rise_q[i]),
      .falling_filter (fall_q[i]),
      .event_reg      (evt_q[i]),
      .enable         (en_q[i]),
      .summary        (sum[i])
    );
  end

  srsl_status_set #(
    .HAS_FILTER  (1'b0),
    .PRESET_ONES (1'b0)
  ) u_std (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .cond           (ZERO16),
    .direct         (std_event_in),
    .wdata          (cmd.data),
    .rise_we        (1'b0),
    .fall_we        (1'b0),
    .en_we          (cmd_valid && is_std && (cmd.op == OP_WR_EN)),
    .rd_clear       (cmd_valid && is_std && (cmd.op == OP_RD_EVENT)),
    .cls            (cls),
    .preset         (1'b0),
    .rising_filter  (),
    .falling_filter (),
    .event_reg      (std_evt),
    .enable         (std_en),
    .summary        (std_event_summary_bit)
  );

  // ************************************************************
  // Queues
  // ************************************************************
  logic            error_ready_bit;
  logic            message_ready_bit;
  logic [EQ_W-1:0] eq_head;
  logic            eq_pop;

  assign eq_pop = cmd_valid && (cmd.op == OP_ERR_Q);

  // Clear-status empties the error queue but keeps pending output
  srsl_fifo #(
    .W (EQ_W),
    .D (EQ_DEPTH)
  ) u_errq (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .clear     (cls),
    .push      (err_push),
    .push_data (err_code),
    .pop       (eq_pop),
    .not_full  (err_ready),
    .not_empty (error_ready_bit),
    .head      (eq_head)
  );

  srsl_fifo #(
    .W (OQ_W),
    .D (OQ_DEPTH)
  ) u_outq (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .clear     (1'b0),
    .push      (oq_push),
    .push_data (oq_data),
    .pop       (talk_pop),
    .not_full  (oq_ready),
    .not_empty (message_ready_bit),
    .head      (talk_data)
  );

  assign talk_valid = message_ready_bit;

  // ************************************************************
  // Status byte and service request
  // ************************************************************
  logic [7:0] sb_sum;
  logic [7:0] service_request_mask;
  logic [7:0] enabled;
  logic [7:0] enabled_q;
  logic       request_for_service_bit;
  logic       rise;

  // Summary bits are wires, so reads of a source clear them at once
  always_comb begin
    sb_sum          = 8'h00;
    sb_sum[SB_MEAS] = sum[SET_MEAS];
    sb_sum[SB_ERR_RDY] = error_ready_bit;
    sb_sum[SB_QUES]    = sum[SET_QUES];
    sb_sum[SB_MSG_RDY] = message_ready_bit;
    sb_sum[SB_STD]     = std_event_summary_bit;
    sb_sum[SB_OPER] = sum[SET_OPER];
  end

  assign enabled        = sb_sum & service_request_mask & SB_SUM_MASK;
  assign master_summary = |enabled;
  assign rise           = |(enabled & ~enabled_q);
  assign srq            = request_for_service_bit;

  always_comb begin
    status_byte         = sb_sum;
    status_byte[SB_REQ] = master_summary;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      service_request_mask <= SRE_RESET;
    end else if (cmd_valid && (cmd.op == OP_WR_SRE)) begin
      service_request_mask <= cmd.data[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      enabled_q <= 8'h00;
    end else begin
      enabled_q <= enabled;
    end
  end

  // A fresh rise beats a poll in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      request_for_service_bit <= 1'b0;
    end else if (rise) begin
      request_for_service_bit <= 1'b1;
    end else if (spoll || cls) begin
      request_for_service_bit <= 1'b0;
    end
  end

  // ************************************************************
  // Read answers
  // ************************************************************
  logic [REG_W-1:0] next_rd_data;
  logic [2:0]       idx;

  assign idx = (cmd.sel == SET_STD) ? 3'h0 : cmd.sel;

  always_comb begin
    next_rd_data = ZERO16;
    case (cmd.op)
      OP_RD_COND:  next_rd_data = is_std ? ZERO16 : cond_eff[idx];
      OP_RD_EVENT: next_rd_data = is_std ? std_evt : evt_q[idx];
      OP_RD_EN:    next_rd_data = is_std ? std_en : en_q[idx];
      OP_RD_RISE:  next_rd_data = is_std ? ZERO16 : rise_q[idx];
      OP_RD_FALL:  next_rd_data = is_std ? ZERO16 : fall_q[idx];
      OP_STB_Q:    next_rd_data = {8'h00, status_byte};
      OP_SPOLL:    next_rd_data = {8'h00, sb_sum[7], request_for_service_bit,
                                   sb_sum[5:0]};
      OP_RD_SRE:   next_rd_data = {8'h00, service_request_mask};
      OP_ERR_Q:    next_rd_data = error_ready_bit ? eq_head : ZERO16;
      default:     next_rd_data = ZERO16;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_data  <= ZERO16;
    end else begin
      rd_valid <= cmd_go;
      rd_data  <= cmd_go ? next_rd_data : rd_data;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  preset_filter_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    preset |=> (rise_q[SET_QUES] == RISE_FILT_RESET) && (fall_q[SET_QUES] == FALL_FILT_RESET))
    else $error("preset did not restore filters");
  preset_enable_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    preset |=> (en_q[SET_OPER] == EN_RESET) && (en_q[SET_ARM] == EN_ALL_ONES))
    else $error("preset enable values wrong");
  msg_ready_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (oq_push && oq_ready && !talk_pop) |=> status_byte[SB_MSG_RDY])
    else $error("message ready not set after push");
  err_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cls |=> !status_byte[SB_ERR_RDY])
    else $error("error ready survived clear status");
  spoll_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spoll && !rise) |=> !srq)
    else $error("serial poll did not reset request");
  spoll_answer_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    spoll |=> rd_valid && (rd_data[SB_REQ] == $past(srq)))
    else $error("serial poll answer bit six wrong");
  rise_request_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rise |=> srq)
    else $error("enabled rise did not request service");
  stb_query_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cmd_valid && cmd.op == OP_STB_Q) |=>
      (rd_data[7:0] == $past(status_byte)) && (srq || !$past(srq)))
    else $error("status query answer wrong or cleared");
  sre_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cmd_valid && cmd.op == OP_WR_SRE && cmd.data[7:0] == 8'h00) |=> !master_summary)
    else $error("zero mask left master summary set");
  summary_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spoll ##1 ($stable(sb_sum) && $stable(service_request_mask))) |->
      $stable(master_summary))
    else $error("poll changed master summary");
endmodule : srsl_top

// File: srsl_pkg.sv
// Purpose: Shared constants and types for the status reporting block
// Assumes: One system clock, asynchronous active-low reset
// Notes:   Register sets are 16 bits wide, status byte is 8 bits
//
// Operation
// - Condition registers read-only, mirror live conditions
// - Standard set lacks condition and filter
// - Rising/falling filters set event on transition
// - Filters writable; reading leaves them unchanged
// - Power-up/preset: rising all ones, falling zeros
// - Event bits sticky until explicitly cleared
// - Summary is OR of event AND enable
// - Event read clears; power-up and clear-status clear
// - Enable zero blocks, one passes event
// - Enable kept on read; power-up clears
// - Preset clears oper/ques/meas, sets trig/arm/seq
// - Writing zero clears standard event enable
// - Output queue FIFO; message-ready while non-empty
// - Reading output queue removes the message
// - Error queue FIFO of ten; error-ready while non-empty
// - Error query read removes the entry
// - Summary status byte bits follow inputs, no latch
// - Common query returns master summary, clears nothing
// - Serial poll returns request bit, then resets it
// - Power-up/clear-status clear byte, message-ready may stay
// - Master summary is OR of enabled summaries
// - Service mask kept on read; zero write clears
// - Enabled summary rise sets request bit
// - Serial poll leaves master summary unchanged
package srsl_pkg;

  localparam int REG_W     = 16;
  localparam int FILT_SETS = 6;
  localparam int EQ_W      = 16;
  localparam int EQ_DEPTH  = 10;
  localparam int OQ_W      = 8;
  localparam int OQ_DEPTH  = 16;

  localparam logic [15:0] RISE_FILT_RESET = 16'hFFFF;
  localparam logic [15:0] FALL_FILT_RESET = 16'h0000;
  localparam logic [15:0] EN_RESET    = 16'h0000;
  localparam logic [15:0] EN_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam logic [7:0]  SRE_RESET   = 8'h00;
  localparam logic [7:0]  SB_SUM_MASK = 8'hBF;

  localparam int SB_MEAS = 0;
  localparam int SB_ERR_RDY = 2;
  localparam int SB_QUES    = 3;
  localparam int SB_MSG_RDY = 4;
  localparam int SB_STD     = 5;
  localparam int SB_REQ     = 6;
  localparam int SB_OPER = 7;

  localparam int OPER_TRIG_BIT = 5;
  localparam int OPER_ARM_BIT  = 6;
  localparam int OPER_SEQ_BIT  = 7;

  typedef enum logic [3:0] {
    OP_NOP     = 4'h0, OP_RD_COND = 4'h1, OP_RD_EVENT = 4'h2, OP_RD_EN   = 4'h3,
    OP_WR_EN   = 4'h4, OP_RD_RISE = 4'h5, OP_WR_RISE  = 4'h6, OP_RD_FALL = 4'h7,
    OP_WR_FALL = 4'h8, OP_CLS     = 4'h9, OP_PRESET   = 4'hA, OP_STB_Q   = 4'hB,
    OP_SPOLL   = 4'hC, OP_WR_SRE  = 4'hD, OP_RD_SRE   = 4'hE, OP_ERR_Q   = 4'hF
  } srsl_op_t;

  typedef enum logic [2:0] {
    SET_OPER = 3'h0, SET_QUES = 3'h1, SET_MEAS = 3'h2,
    SET_TRIG = 3'h3, SET_ARM  = 3'h4, SET_SEQ  = 3'h5, SET_STD = 3'h6
  } srsl_set_t;

  typedef struct packed {
    srsl_op_t    op;
    srsl_set_t   sel;
    logic [15:0] data;
  } srsl_cmd_t;

endpackage : srsl_pkg

// File: srsl_fifo.sv
// Purpose: Small first-in first-out queue
// Assumes: Push ignored when full, pop ignored when empty
// Notes:   Head word is visible while not empty
`timescale 1ns/1ps
module srsl_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         clear,
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  input  wire logic         pop,
  output logic              not_full,
  output logic              not_empty,
  output logic [W-1:0]      head
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          do_push;
  logic          do_pop;

  assign not_full  = (count != FULL);
  assign not_empty = (count != '0);
  assign do_push   = push && not_full && !clear;
  assign do_pop    = pop && not_empty && !clear;
  assign head      = mem[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule : srsl_fifo

// File: srsl_status_set.sv
// Purpose: One status register set: filter, event, enable, summary
// Assumes: Direct event inputs used only when no filter is present
// Notes:   Preset value of the enable register is chosen per instance
`timescale 1ns/1ps
module srsl_status_set
  import srsl_pkg::*;
#(
  parameter bit HAS_FILTER  = 1'b1,
  parameter bit PRESET_ONES = 1'b0
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [REG_W-1:0] cond,
  input  wire logic [REG_W-1:0] direct,
  input  wire logic [REG_W-1:0] wdata,
  input  wire logic             rise_we,
  input  wire logic             fall_we,
  input  wire logic             en_we,
  input  wire logic             rd_clear,
  input  wire logic             cls,
  input  wire logic             preset,
  output logic [REG_W-1:0]      rising_filter,
  output logic [REG_W-1:0]      falling_filter,
  output logic [REG_W-1:0]      event_reg,
  output logic [REG_W-1:0]      enable,
  output logic                  summary
);
  logic [REG_W-1:0] cond_q;
  logic [REG_W-1:0] hits;

  // Standard set has no filter, events arrive as pulses
  assign hits = HAS_FILTER ? ((cond & ~cond_q & rising_filter) |
                              (~cond & cond_q & falling_filter))
                           : direct;
  assign summary = |(event_reg & enable);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cond_q <= ZERO16;
    end else begin
      cond_q <= cond;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rising_filter  <= RISE_FILT_RESET;
      falling_filter <= FALL_FILT_RESET;
    end else if (preset) begin
      rising_filter  <= RISE_FILT_RESET;
      falling_filter <= FALL_FILT_RESET;
    end else begin
      if (rise_we) begin
        rising_filter <= wdata;
      end
      if (fall_we) begin
        falling_filter <= wdata;
      end
    end
  end

  // Set wins over clear so no event slips through a read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      event_reg <= ZERO16;
    end else begin
      event_reg <= ((rd_clear || cls) ? ZERO16 : event_reg) | hits;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      enable <= EN_RESET;
    end else if (preset && HAS_FILTER) begin
      enable <= PRESET_ONES ? EN_ALL_ONES : EN_RESET;
    end else if (en_we) begin
      enable <= wdata;
    end
  end

  sticky_event_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!rd_clear && !cls) |=> ((event_reg & $past(event_reg)) == $past(event_reg)))
    else $error("event bit dropped without a clear");
  win_over_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rd_clear |=> (event_reg == $past(hits)))
    else $error("read clear lost a coincident event");
endmodule : srsl_status_set

// File: srsl_ctl_model.sv
// Purpose: Bus controller model issuing queries, writes and polls
// Assumes: Answer lands on the edge that takes the command
// Notes:   Drives just after the rising edge, never on it
`timescale 1ns/1ps
module srsl_ctl_model
  import srsl_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             cmd_valid,
  output srsl_cmd_t        cmd,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  // ****************
  // Command issue
  // ****************
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end
  // Idle data inverted so a stale command cannot pass as held
  task automatic xfer(input srsl_op_t op, input srsl_set_t sel, input logic [15:0] d,
                      output logic [15:0] ans, output logic ok);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd       = '{op, sel, d};
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmd       = '{OP_NOP, SET_STD, ~d};
    ans       = rd_data;
    ok        = rd_valid;
  endtask : xfer
endmodule : srsl_ctl_model

// File: srsl_top_tb.sv
// Purpose: Self-checking bench for the status reporting block
// Assumes: Controller model drives the command port
// Notes:   Table rows first, then hand-written event and queue cases
`timescale 1ns/1ps
module srsl_top_tb
  import srsl_pkg::*;
;
  typedef struct packed {
    srsl_op_t    op;
    srsl_set_t   sel;
    logic [15:0] d;
    logic [15:0] e;
  } srsl_row_t;
  logic                            sys_clk, nrst, cmd_valid, rd_valid, ok;
  logic                            err_push, err_ready, oq_push, oq_ready, talk_pop;
  logic                            talk_valid, master_summary, srq;
  srsl_cmd_t                       cmd;
  logic [15:0]                     rd_data, std_event_in, err_code, ans;
  logic [FILT_SETS-1:0][REG_W-1:0] cond_in;
  logic [7:0]                      oq_data, talk_data, status_byte;
  int                              failures, comparisons, cycles;
  srsl_row_t rows [17] = '{
    '{OP_RD_RISE, SET_OPER, 16'h0000, 16'hFFFF}, '{OP_RD_FALL, SET_OPER, 16'h0000, 16'h0000},
    '{OP_RD_EN,  SET_QUES, 16'h0000, 16'h0000}, '{OP_RD_SRE, SET_STD,  16'h0000, 16'h0000},
    '{OP_WR_RISE, SET_MEAS, 16'h00FF, 16'h0000}, '{OP_RD_RISE, SET_MEAS, 16'h0000, 16'h00FF},
    '{OP_RD_RISE, SET_MEAS, 16'h0000, 16'h00FF}, '{OP_WR_EN,  SET_MEAS, 16'h0003, 16'h0000},
    '{OP_RD_EN,  SET_MEAS, 16'h0000, 16'h0003}, '{OP_WR_EN,  SET_STD,  16'h00FF, 16'h0000},
    '{OP_WR_EN,  SET_STD,  16'h0000, 16'h0000}, '{OP_RD_EN,  SET_STD,  16'h0000, 16'h0000},
    '{OP_WR_SRE, SET_STD,  16'h0081, 16'h0000}, '{OP_RD_SRE, SET_STD,  16'h0000, 16'h0081},
    '{OP_PRESET, SET_STD,  16'h0000, 16'h0000}, '{OP_RD_EN,  SET_MEAS, 16'h0000, 16'h0000},
    '{OP_RD_EN,  SET_TRIG, 16'h0000, 16'hFFFF}};
  srsl_top dut (.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
    .rd_valid(rd_valid), .rd_data(rd_data), .cond_in(cond_in), .std_event_in(std_event_in),
    .err_push(err_push), .err_code(err_code), .err_ready(err_ready), .oq_push(oq_push),
    .oq_data(oq_data), .oq_ready(oq_ready), .talk_pop(talk_pop), .talk_valid(talk_valid),
    .talk_data(talk_data), .status_byte(status_byte), .master_summary(master_summary),
    .srq(srq));
  srsl_ctl_model ctl (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .rd_valid(rd_valid), .rd_data(rd_data));
  // ****************
  // Checking
  // ****************
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic finish_test;
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard, well above the roughly 130 cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    nrst = 1'b0; cond_in = '0; std_event_in = '0; err_push = 1'b0; err_code = '0;
    oq_push = 1'b0; oq_data = '0; talk_pop = 1'b0;
    tick(20);
    nrst = 1'b1;
    chk("stb_rst", status_byte, 8'h00);
    foreach (rows[i]) begin
      ctl.xfer(rows[i].op, rows[i].sel, rows[i].d, ans, ok);
      chk("row", ans, rows[i].e);
      chk("rd_valid", ok, 1'b1);
    end
    ctl.xfer(OP_WR_EN, SET_QUES, 16'h0001, ans, ok);
    ctl.xfer(OP_WR_SRE, SET_STD, 16'h0008, ans, ok);
    cond_in[1] = 16'h0001;
    tick(4);
    chk("stb_ev", status_byte, 8'h48);
    chk("srq_set", srq, 1'b1);
    ctl.xfer(OP_RD_COND, SET_QUES, 16'h0000, ans, ok);
    chk("cond", ans, 16'h0001);
    ctl.xfer(OP_STB_Q, SET_STD, 16'h0000, ans, ok);
    chk("stb_q", ans, 16'h0048);
    chk("stb_q_srq", srq, 1'b1);
    ctl.xfer(OP_SPOLL, SET_STD, 16'h0000, ans, ok);
    chk("poll1", ans, 16'h0048);
    chk("poll1_srq", {srq, master_summary}, 2'b01);
    ctl.xfer(OP_SPOLL, SET_STD, 16'h0000, ans, ok);
    chk("poll2", ans, 16'h0008);
    ctl.xfer(OP_WR_EN, SET_QUES, 16'h0000, ans, ok);
    chk("masked", status_byte, 8'h00);
    ctl.xfer(OP_WR_EN, SET_QUES, 16'h0001, ans, ok);
    tick(2);
    chk("srq_again", srq, 1'b1);
    ctl.xfer(OP_RD_EVENT, SET_QUES, 16'h0000, ans, ok);
    chk("ev_rd", ans, 16'h0001);
    chk("ev_rd_stb", status_byte, 8'h00);
    ctl.xfer(OP_WR_RISE, SET_QUES, 16'h0000, ans, ok);
    ctl.xfer(OP_WR_FALL, SET_QUES, 16'h0001, ans, ok);
    cond_in[1] = 16'h0000;
    tick(3);
    ctl.xfer(OP_RD_EVENT, SET_QUES, 16'h0000, ans, ok);
    chk("ev_fall", ans, 16'h0001);
    ctl.xfer(OP_WR_EN, SET_STD, 16'h0001, ans, ok);
    std_event_in = 16'h0001;
    tick(1);
    std_event_in = '0;
    chk("std_ev", status_byte[5], 1'b1);
    oq_push = 1'b1;
    oq_data = 8'hA5;
    tick(1);
    oq_push = 1'b0;
    chk("oq", {talk_valid, status_byte[4], oq_ready, talk_data}, {3'b111, 8'hA5});
    ctl.xfer(OP_CLS, SET_STD, 16'h0000, ans, ok);
    chk("cls", {status_byte, srq}, {8'h10, 1'b0});
    talk_pop = 1'b1;
    tick(1);
    talk_pop = 1'b0;
    tick(1);
    chk("pop", {talk_valid, status_byte}, 9'h000);
    for (int i = 0; i < 11; i++) begin
      err_push = 1'b1;
      err_code = 16'h0100 + 16'(i);
      tick(1);
    end
    err_push = 1'b0;
    tick(1);
    chk("eq_full", {err_ready, status_byte[2]}, 2'b01);
    for (int i = 0; i < 10; i++) begin
      ctl.xfer(OP_ERR_Q, SET_STD, 16'h0000, ans, ok);
      chk("eq", ans, 16'h0100 + 16'(i));
    end
    tick(1);
    chk("eq_empty", status_byte[2], 1'b0);
    finish_test();
  end
endmodule : srsl_top_tb
